// >>> pkg/cpct_pkg.sv
// Purpose: Shared constants and types of the cascadable PWM and capture timer.
// Assumes: Byte-wide register port, three timer channels of eight registers each.
// Notes:   Every offset, field position and reset value of the counter, reload, PWM, control and mask registers is named here once.
package cpct_pkg;
    localparam int NUM_CH = 3;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;
    localparam int PRE_CW = 7;

    // Register index inside a channel; the channel number sits in the address bits above.
    localparam logic [2:0] REG_CNT_HI = 3'h0;
    localparam logic [2:0] REG_CNT_LO = 3'h1;
    localparam logic [2:0] REG_RLD_HI = 3'h2;
    localparam logic [2:0] REG_RLD_LO = 3'h3;
    localparam logic [2:0] REG_PWM_HI = 3'h4;
    localparam logic [2:0] REG_PWM_LO = 3'h5;
    localparam logic [2:0] REG_CTL0   = 3'h6;
    localparam logic [2:0] REG_CTL1   = 3'h7;

    localparam logic [4:0] ADDR_IRQ_STAT = 5'h18;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h19;

    localparam int CTL1_EN_BIT   = 7;
    localparam int CTL1_POL_BIT  = 6;
    localparam int CTL1_PRE_LSB  = 3;
    localparam int CTL1_MODE_LSB = 0;
    localparam int CTL0_CASC_BIT = 7;
    localparam int CTL0_CFG_LSB  = 5;
    localparam int CTL0_OEN_BIT  = 4;
    localparam int CTL0_CAPF_BIT = 0;

    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] CNT_START = 16'h0001;
    localparam logic [15:0] RLD_RST   = 16'hFFFF;
    localparam logic [15:0] PWM_RST   = 16'h0000;
    localparam logic [7:0]  CTL_RST   = 8'h00;
    localparam logic [7:0]  MASK_RST  = 8'h00;

    localparam logic [1:0] CFG_CAP_ONLY = 2'h2;
    localparam logic [1:0] CFG_RLD_ONLY = 2'h3;

    typedef enum logic [2:0]
    {
        MODE_ONESHOT,
        MODE_CONT,
        MODE_PWM,
        MODE_CAPTURE,
        MODE_CAP_RESTART,
        MODE_CAP_COMPARE
    } cpct_mode_type;
endpackage

// >>> hdl/cpct_timer.sv
// Purpose: Three cascadable 16-bit timers with PWM, capture and an atomic count read.
// Assumes: Timer input pins and the comparator output are asynchronous to clk_sys_in.
// Notes:   Register reads return data in the cycle after the read strobe.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

// Behaviour
// - PWM period is reload times prescale.
// - First period runs from the current count, zero after reset.
// - Polarity 0: high for reload minus PWM.
// - Polarity 1: high for PWM value counts.
// - Three capture modes copy count to PWM.
// - Polarity picks capture edge, rising or falling.
// - Source field picks capture, reload or both.
// - Capture flag set by capture, cleared by reload.
// - Capture modes toggle output at reload.
// - Count readable as bytes without disturbing counting.
// - High byte read latches low byte when enabled.
// - Disabled low byte read returns live count.
// - Byte writes load the counter next edge.
// - Cascaded first timer counts comparator edges.
// - Cascaded later timers count preceding timer.
// - Cascade works in all modes but capture restart, and in chains without back-to-back reloads.
module cpct_timer
#(
    parameter int NUM_CH = cpct_pkg::NUM_CH
)
(
    input  wire logic                          clk_sys_in,
    input  wire logic                          rst_in,
    input  wire logic                          ce_in,
    input  wire logic [cpct_pkg::ADDR_W-1:0]   addr_in,
    input  wire logic [cpct_pkg::DATA_W-1:0]   wdata_in,
    input  wire logic                          wr_in,
    input  wire logic                          rd_in,
    output logic      [cpct_pkg::DATA_W-1:0]   rdata_out,
    input  wire logic [NUM_CH-1:0]             timer_in_in,
    input  wire logic                          comparator_in,
    output logic      [NUM_CH-1:0]             timer_out_out,
    output logic      [NUM_CH-1:0]             timer_out_oe_out,
    output logic                               irq_out
);
    // Pin synchronisers; the first stage is read only by the second.
    logic [NUM_CH-1:0] pin_meta_r;
    logic [NUM_CH-1:0] pin_sync_r;
    logic              comp_meta_r;
    logic              comp_sync_r;

    logic [NUM_CH-1:0] rld_pulse;
    logic [NUM_CH-1:0] irq_evt;
    logic [7:0]        rd_val [NUM_CH];
    logic [7:0]        stat_r;
    logic [7:0]        mask_r;
    logic [7:0]        stat_nxt;
    logic [7:0]        rdata_nxt;
    logic [2:0]        reg_sel;
    logic [1:0]        ch_sel;

    assign reg_sel = addr_in[2:0];
    assign ch_sel  = addr_in[4:3];

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_meta_r  <= '0;
            pin_sync_r  <= '0;
            comp_meta_r <= 1'b0;
            comp_sync_r <= 1'b0;
        end
        else if (ce_in)
        begin
            pin_meta_r  <= timer_in_in;
            pin_sync_r  <= pin_meta_r;
            comp_meta_r <= comparator_in;
            comp_sync_r <= comp_meta_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            logic [15:0]              cnt_r;
            logic [15:0]              rld_r;
            logic [15:0]              pwm_r;
            logic [7:0]               ctl0_r;
            logic [7:0]               ctl1_r;
            logic [7:0]               hold_r;
            logic [cpct_pkg::PRE_CW-1:0] pre_r;
            logic [cpct_pkg::PRE_CW-1:0] pre_max;
            logic                     out_r;
            logic                     src_prev_r;
            logic                     src_lvl;
            logic                     src_rise;
            logic                     src_fall;
            logic                     en;
            logic                     pol;
            logic                     casc;
            logic [1:0]               cfg;
            logic [2:0]               pre_exp;
            cpct_pkg::cpct_mode_type  mode;
            logic                     is_cap;
            logic                     wr_hit;
            logic                     advance;
            logic                     at_rld;
            logic                     rld_evt;
            logic                     cap_evt;
            logic                     irq_cap;
            logic                     irq_rld;
            logic                     en_rise;

            assign en      = ctl1_r[cpct_pkg::CTL1_EN_BIT];
            assign pol     = ctl1_r[cpct_pkg::CTL1_POL_BIT];
            assign pre_exp = ctl1_r[cpct_pkg::CTL1_PRE_LSB +: 3];
            assign mode    = cpct_pkg::cpct_mode_type'(ctl1_r[cpct_pkg::CTL1_MODE_LSB +: 3]);
            assign casc    = ctl0_r[cpct_pkg::CTL0_CASC_BIT];
            assign cfg     = ctl0_r[cpct_pkg::CTL0_CFG_LSB +: 2];
            assign is_cap  = (mode == cpct_pkg::MODE_CAPTURE)
                          || (mode == cpct_pkg::MODE_CAP_RESTART)
                          || (mode == cpct_pkg::MODE_CAP_COMPARE);
            assign wr_hit  = wr_in && (ch_sel == 2'(gi));

            // The input source is redefined when cascading.
            if (gi == 0)
            begin : g_src0
                assign src_lvl = casc ? comp_sync_r : pin_sync_r[gi];
            end
            else
            begin : g_srcn
                assign src_lvl = casc ? rld_pulse[gi-1] : pin_sync_r[gi];
            end

            assign src_rise = src_lvl & ~src_prev_r;
            assign src_fall = ~src_lvl & src_prev_r;

            // A cascaded timer counts source edges instead of prescaled clocks in any mode.
            // At the top exponent the shift wraps to zero, so the result is all ones.
            assign pre_max = ({{(cpct_pkg::PRE_CW-1){1'b0}}, 1'b1} << pre_exp) - 1'b1;
            assign advance = casc ? src_rise : (pre_r == pre_max);
            assign at_rld  = (cnt_r == rld_r);
            assign rld_evt = en && advance && at_rld;
            assign cap_evt = en && is_cap && (pol ? src_fall : src_rise);
            assign irq_cap = cap_evt && (cfg != cpct_pkg::CFG_RLD_ONLY);
            assign irq_rld = rld_evt && (!is_cap || (cfg != cpct_pkg::CFG_CAP_ONLY));
            assign en_rise = wr_hit && (reg_sel == cpct_pkg::REG_CTL1)
                          && wdata_in[cpct_pkg::CTL1_EN_BIT] && !en;

            assign rld_pulse[gi] = rld_evt;
            assign irq_evt[gi]   = irq_cap | irq_rld;
            assign timer_out_out[gi]    = out_r;
            assign timer_out_oe_out[gi] = ctl0_r[cpct_pkg::CTL0_OEN_BIT];

            always_ff @(posedge clk_sys_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    src_prev_r <= 1'b0;
                end
                else if (ce_in)
                begin
                    src_prev_r <= src_lvl;
                end
            end

            always_ff @(posedge clk_sys_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    pre_r <= '0;
                end
                else if (ce_in)
                begin
                    if (!en || casc || (pre_r == pre_max))
                    begin
                        pre_r <= '0;
                    end
                    else
                    begin
                        pre_r <= pre_r + 1'b1;
                    end
                end
            end

            // Bus writes land directly in the counter; there is no write holding register.
            always_ff @(posedge clk_sys_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    cnt_r <= cpct_pkg::CNT_RST;
                end
                else if (ce_in)
                begin
                    if (wr_hit && reg_sel == cpct_pkg::REG_CNT_HI)
                    begin
                        cnt_r <= {wdata_in, cnt_r[7:0]};
                    end
                    else if (wr_hit && reg_sel == cpct_pkg::REG_CNT_LO)
                    begin
                        cnt_r <= {cnt_r[15:8], wdata_in};
                    end
                    else if (cap_evt && mode == cpct_pkg::MODE_CAP_RESTART)
                    begin
                        cnt_r <= cpct_pkg::CNT_START;
                    end
                    else if (en && advance)
                    begin
                        cnt_r <= at_rld ? cpct_pkg::CNT_START : cnt_r + 16'h0001;
                    end
                end
            end

            always_ff @(posedge clk_sys_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    rld_r <= cpct_pkg::RLD_RST;
                end
                else if (ce_in && wr_hit)
                begin
                    if (reg_sel == cpct_pkg::REG_RLD_HI)
                    begin
                        rld_r[15:8] <= wdata_in;
                    end
                    else if (reg_sel == cpct_pkg::REG_RLD_LO)
                    begin
                        rld_r[7:0] <= wdata_in;
                    end
                end
            end

            always_ff @(posedge clk_sys_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    pwm_r <= cpct_pkg::PWM_RST;
                end
                else if (ce_in)
                begin
                    if (cap_evt)
                    begin
                        pwm_r <= cnt_r;
                    end
                    else if (wr_hit && reg_sel == cpct_pkg::REG_PWM_HI)
                    begin
                        pwm_r[15:8] <= wdata_in;
                    end
                    else if (wr_hit && reg_sel == cpct_pkg::REG_PWM_LO)
                    begin
                        pwm_r[7:0] <= wdata_in;
                    end
                end
            end

            // A one-shot timer turns itself off at its reload.
            always_ff @(posedge clk_sys_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    ctl1_r <= cpct_pkg::CTL_RST;
                end
                else if (ce_in)
                begin
                    if (wr_hit && reg_sel == cpct_pkg::REG_CTL1)
                    begin
                        ctl1_r <= wdata_in;
                    end
                    else if (rld_evt && mode == cpct_pkg::MODE_ONESHOT)
                    begin
                        ctl1_r[cpct_pkg::CTL1_EN_BIT] <= 1'b0;
                    end
                end
            end

            // The capture flag is hardware owned; a capture in the same cycle wins.
            always_ff @(posedge clk_sys_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    ctl0_r <= cpct_pkg::CTL_RST;
                end
                else if (ce_in)
                begin
                    if (wr_hit && reg_sel == cpct_pkg::REG_CTL0)
                    begin
                        ctl0_r[7:1] <= wdata_in[7:1];
                    end
                    if (irq_cap)
                    begin
                        ctl0_r[cpct_pkg::CTL0_CAPF_BIT] <= 1'b1;
                    end
                    else if (irq_rld)
                    begin
                        ctl0_r[cpct_pkg::CTL0_CAPF_BIT] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge clk_sys_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    hold_r <= 8'h00;
                end
                else if (ce_in && rd_in && en && ch_sel == 2'(gi)
                         && reg_sel == cpct_pkg::REG_CNT_HI)
                begin
                    hold_r <= cnt_r[7:0];
                end
            end

            // The PWM level follows the registered count, so edges lag the count by a cycle.
            always_ff @(posedge clk_sys_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    out_r <= 1'b0;
                end
                else if (ce_in)
                begin
                    if (en_rise)
                    begin
                        out_r <= wdata_in[cpct_pkg::CTL1_POL_BIT];
                    end
                    else if (en && mode == cpct_pkg::MODE_PWM)
                    begin
                        if (pol)
                        begin
                            out_r <= (cnt_r <= pwm_r);
                        end
                        else
                        begin
                            out_r <= (cnt_r > pwm_r);
                        end
                    end
                    else if (rld_evt)
                    begin
                        out_r <= ~out_r;
                    end
                end
            end

            always_comb
            begin
                case (reg_sel)
                    cpct_pkg::REG_CNT_HI: rd_val[gi] = cnt_r[15:8];
                    cpct_pkg::REG_CNT_LO: rd_val[gi] = en ? hold_r : cnt_r[7:0];
                    cpct_pkg::REG_RLD_HI: rd_val[gi] = rld_r[15:8];
                    cpct_pkg::REG_RLD_LO: rd_val[gi] = rld_r[7:0];
                    cpct_pkg::REG_PWM_HI: rd_val[gi] = pwm_r[15:8];
                    cpct_pkg::REG_PWM_LO: rd_val[gi] = pwm_r[7:0];
                    cpct_pkg::REG_CTL0:   rd_val[gi] = ctl0_r;
                    cpct_pkg::REG_CTL1:   rd_val[gi] = ctl1_r;
                    default:              rd_val[gi] = 8'h00;
                endcase
            end
        end
    endgenerate

    // Status bits are write-one-to-clear; a new event in the same cycle stays set.
    always_comb
    begin
        stat_nxt = stat_r;
        if (wr_in && addr_in == cpct_pkg::ADDR_IRQ_STAT)
        begin
            stat_nxt = stat_nxt & ~wdata_in;
        end
        stat_nxt = stat_nxt | {{(8-NUM_CH){1'b0}}, irq_evt};
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            stat_r <= 8'h00;
        end
        else if (ce_in)
        begin
            stat_r <= stat_nxt;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mask_r <= cpct_pkg::MASK_RST;
        end
        else if (ce_in && wr_in && addr_in == cpct_pkg::ADDR_IRQ_MASK)
        begin
            mask_r <= wdata_in;
        end
    end

    assign irq_out = |(stat_r & mask_r);

    // Unmapped addresses read as zero.
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (addr_in == cpct_pkg::ADDR_IRQ_STAT)
        begin
            rdata_nxt = stat_r;
        end
        else if (addr_in == cpct_pkg::ADDR_IRQ_MASK)
        begin
            rdata_nxt = mask_r;
        end
        else if (32'(ch_sel) < NUM_CH)
        begin
            rdata_nxt = rd_val[ch_sel];
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_out <= 8'h00;
        end
        else if (ce_in)
        begin
            rdata_out <= rd_in ? rdata_nxt : 8'h00;
        end
    end
endmodule // cpct_timer

// >>> tb/cpct_pins_model.sv
// Purpose: Pin-side partner that drives the timer input pins and the comparator output.
// Assumes: Edges are placed 3 ns after a clock edge, away from the sampling instant.
// Notes:   A fixed phase keeps the synchroniser latency equal from one event to the next.
`timescale 1ns/1ps
module cpct_pins_model
(
    output logic [2:0] timer_pin_out,
    output logic       cmp_out
);
    initial
    begin
        timer_pin_out = 3'h0;
        cmp_out       = 1'b0;
    end

    task automatic set_pin(input int ch, input logic lvl);
        #3 timer_pin_out[ch] = lvl;
    endtask

    // Eight cycles per pulse leaves the synchroniser time to see both edges.
    task automatic cmp_pulse();
        #3 cmp_out = 1'b1;
        #100 cmp_out = 1'b0;
        #97;
    endtask
endmodule // cpct_pins_model

// >>> tb/cpct_timer_chk.sv
// Purpose: Port-level assertions for the three-channel timer.
// Assumes: Single clock domain with an active-high asynchronous reset.
// Notes:   The output-enable set check decodes channel 0 only; the hold check covers all channels.
`timescale 1ns/1ps
module cpct_timer_chk
#(
    parameter int NUM_CH = cpct_pkg::NUM_CH
)
(
    input wire logic                        clk_sys_in,
    input wire logic                        rst_in,
    input wire logic                        ce_in,
    input wire logic [cpct_pkg::ADDR_W-1:0] addr_in,
    input wire logic [cpct_pkg::DATA_W-1:0] wdata_in,
    input wire logic                        wr_in,
    input wire logic                        rd_in,
    input wire logic [cpct_pkg::DATA_W-1:0] rdata_out,
    input wire logic [NUM_CH-1:0]           timer_out_out,
    input wire logic [NUM_CH-1:0]           timer_out_oe_out,
    input wire logic                        irq_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    property p_rd_idle; (ce_in && !rd_in) |=> rdata_out == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped; (ce_in && rd_in && addr_in > 5'h19) |=> rdata_out == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rld_back;
        (ce_in && wr_in && addr_in[2:1] == 2'h1 && addr_in[4:3] != 2'h3)
        ##1 (ce_in && rd_in && addr_in == $past(addr_in)) |=> rdata_out == $past(wdata_in, 2);
    endproperty
    a_rld_back: assert property (p_rld_back) else $error("reload readback wrong");
    property p_ctl0_back;
        (ce_in && wr_in && addr_in[2:0] == 3'h6 && addr_in[4:3] != 2'h3)
        ##1 (ce_in && rd_in && addr_in == $past(addr_in)) |=> rdata_out[7:4] == $past(wdata_in[7:4], 2);
    endproperty
    a_ctl0_back: assert property (p_ctl0_back) else $error("control 0 readback wrong");
    property p_oe_set; (ce_in && wr_in && addr_in == 5'h06) |=> timer_out_oe_out[0] == $past(wdata_in[4]); endproperty
    a_oe_set: assert property (p_oe_set) else $error("output enable not taken");
    property p_oe_hold; !(ce_in && wr_in && addr_in[2:0] == 3'h6) |=> $stable(timer_out_oe_out); endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("output enable moved");
    property p_mask_off; (ce_in && wr_in && addr_in == 5'h19 && wdata_in == 8'h00) |=> ##[0:1] !irq_out; endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq with mask clear");
    property p_freeze; !ce_in |=> $stable(timer_out_out) && $stable(irq_out); endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
endmodule // cpct_timer_chk

bind cpct_timer cpct_timer_chk #(.NUM_CH(NUM_CH)) u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .timer_out_out(timer_out_out), .timer_out_oe_out(timer_out_oe_out),
    .irq_out(irq_out));

// >>> tb/tb.sv
// Purpose: Self-checking bench for the cascadable PWM and capture timer.
// Assumes: Register port with read data in the cycle after the strobe.
// Notes:   Pin edges come from the partner model; only the restart interval allows one cycle of slack.
`timescale 1ns/1ps
module tb;
    logic        clk_sys;
    logic        rst;
    logic        ce;
    logic [4:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [2:0]  tin;
    logic        cmp;
    logic [2:0]  tout;
    logic [2:0]  toe;
    logic        irq;
    logic [7:0]  d;
    logic [15:0] v1;
    logic [15:0] v2;
    int          num_errors;
    int          num_checks;
    int          seed;
    int          cycles;
    int          p;
    int          hi;
    int          rises;

    cpct_timer #(.NUM_CH(3)) u_dut (.clk_sys_in(clk_sys), .rst_in(rst), .ce_in(ce), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .timer_in_in(tin),
        .comparator_in(cmp), .timer_out_out(tout), .timer_out_oe_out(toe), .irq_out(irq));
    cpct_pins_model u_pins (.timer_pin_out(tin), .cmp_out(cmp));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            $display("[ERR] cycles expected 20000 seen %0d", cycles);
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (exp !== got)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [4:0] a, output logic [7:0] q);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 q = rdata;
    endtask

    task automatic rd16(input logic [4:0] a, output logic [15:0] q);
        rd_reg(a, q[15:8]);
        rd_reg(a + 5'h01, q[7:0]);
    endtask

    // Counts high samples and rising transitions over n cycles of one output.
    task automatic measure(input int ch, input int n, output int h, output int r);
        logic prev;
        prev = tout[ch];
        h = 0;
        r = 0;
        repeat (n)
        begin
            @(posedge clk_sys);
            #1;
            r += (tout[ch] && !prev);
            h += tout[ch];
            prev = tout[ch];
        end
    endtask

    initial
    begin
        seed = 32'h2B0D5576;
        {rst, ce, addr, wdata, wr, rd} = {1'b1, 1'b1, 5'h00, 8'h00, 1'b0, 1'b0};
        {num_errors, num_checks, cycles} = {32'h0, 32'h0, 32'h0};
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        ce <= 1'b0;
        repeat (3) @(posedge clk_sys);
        ce <= 1'b1;
        for (int a = 0; a < 32; a++)
        begin
            rd_reg(5'(a), d);
            check("reset value", (a < 24 && a % 8 inside {2, 3}) ? 16'h00FF : 16'h0000, 16'(d));
        end
        p = 1 + ($unsigned($random(seed)) % 8);
        wr_reg(5'h19, 8'h00);
        for (int pol = 0; pol < 2; pol++)
        begin
            wr_reg(5'h07, 8'h00);
            wr_reg(5'h02, 8'h00);
            wr_reg(5'h03, 8'h0A);
            wr_reg(5'h05, 8'(p));
            wr_reg(5'h06, 8'h10);
            wr_reg(5'h07, 8'h8A | 8'(pol << 6));
            repeat (50) @(posedge clk_sys);
            measure(0, 80, hi, rises);
            check("pwm periods", 16'd4, 16'(rises));
            check("pwm high", 16'(pol ? 8 * p : 8 * (10 - p)), 16'(hi));
        end
        wr_reg(5'h10, 8'h12);
        wr_reg(5'h11, 8'hFF);
        rd_reg(5'h11, d);
        check("idle count low", 16'h00FF, 16'(d));
        wr_reg(5'h17, 8'h81);
        repeat (5) @(posedge clk_sys);
        rd16(5'h10, v1);
        repeat (7) @(posedge clk_sys);
        rd_reg(5'h11, d);
        check("held count low", 16'(v1[7:0]), 16'(d));
        check("count window", 16'h0001, 16'(v1 > 16'h12FF && v1 < 16'h1320));
        wr_reg(5'h17, 8'h01);
        wr_reg(5'h11, 8'h55);
        rd_reg(5'h11, d);
        check("live count low", 16'h0055, 16'(d));
        wr_reg(5'h19, 8'h02);
        for (int m = 3; m < 6; m++)
        begin
            wr_reg(5'h0F, 8'h00);
            wr_reg(5'h0E, 8'h40);
            wr_reg(5'h0F, 8'h80 | 8'(m));
            fork
                begin
                    @(posedge clk_sys);
                    u_pins.set_pin(1, 1'b1);
                    repeat (20) @(posedge clk_sys);
                    u_pins.set_pin(1, 1'b0);
                    repeat (20) @(posedge clk_sys);
                    u_pins.set_pin(1, 1'b1);
                end
                begin
                    repeat (8) @(posedge clk_sys);
                    #1 check("capture irq", 16'h0001, 16'(irq));
                    rd16(5'h0C, v1);
                    rd_reg(5'h0E, d);
                    check("capture flag", 16'h0001, 16'(d[0]));
                    wr_reg(5'h18, 8'h02);
                    repeat (12) @(posedge clk_sys);
                    #1 check("falling ignored", 16'h0000, 16'(irq));
                end
            join
            repeat (10) @(posedge clk_sys);
            rd16(5'h0C, v2);
            wr_reg(5'h18, 8'h02);
            u_pins.set_pin(1, 1'b0);
            if (m == 4)
                check("restart interval", 16'h0001, 16'(v2 > 16'd38 && v2 < 16'd42));
            else
                check("capture interval", 16'd40, v2 - v1);
        end
        wr_reg(5'h0F, 8'h00);
        wr_reg(5'h19, 8'h00);
        wr_reg(5'h18, 8'h02);
        wr_reg(5'h08, 8'h00);
        wr_reg(5'h09, 8'h01);
        wr_reg(5'h0A, 8'h00);
        wr_reg(5'h0B, 8'd20);
        wr_reg(5'h0E, 8'h70);
        wr_reg(5'h0F, 8'hC3);
        #1 check("toggle start", 16'h0001, 16'(tout[1]));
        repeat (10) @(posedge clk_sys);
        measure(1, 80, hi, rises);
        check("toggle periods", 16'd2, 16'(rises));
        check("masked irq", 16'h0000, 16'(irq));
        rd_reg(5'h18, d);
        check("reload status", 16'h0001, 16'(d[1]));
        wr_reg(5'h19, 8'h02);
        @(posedge clk_sys);
        #1 check("unmasked irq", 16'h0001, 16'(irq));
        rd_reg(5'h0E, d);
        check("reload flag", 16'h0000, 16'(d[0]));
        wr_reg(5'h19, 8'h00);
        for (int c = 0; c < 3; c++)
        begin
            wr_reg(5'(c * 8 + 7), 8'h00);
            wr_reg(5'(c * 8), 8'h00);
            wr_reg(5'(c * 8 + 1), 8'(c < 2));
            wr_reg(5'(c * 8 + 2), c < 2 ? 8'h00 : 8'hFF);
            wr_reg(5'(c * 8 + 3), c < 2 ? 8'h02 : 8'hFF);
            wr_reg(5'(c * 8 + 6), 8'h80);
        end
        for (int c = 0; c < 3; c++)
            wr_reg(5'(c * 8 + 7), 8'h81 | 8'(($unsigned($random(seed)) % 8) << 3));
        repeat (4) u_pins.cmp_pulse();
        repeat (10) @(posedge clk_sys);
        for (int c = 0; c < 3; c++)
        begin
            wr_reg(5'(c * 8 + 7), 8'h01);
            rd16(5'(c * 8), v1);
            check("cascade count", 16'h0001, v1);
        end
        report_and_stop();
    end
endmodule // tb
